// file: design/bus_pkg.sv
// shared constants for the multiplexed address/data bus ends
package bus_pkg;
  // =========================================================
  // widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int EXT_W = 7;
  localparam int ST_W = 4;
  // =========================================================
  // transaction kinds on the status lines
  localparam logic [ST_W-1:0] ST_NULL = 4'h0;
  localparam logic [ST_W-1:0] ST_REFRESH = 4'h1;
  localparam logic [ST_W-1:0] ST_IO = 4'h2;
  localparam logic [ST_W-1:0] ST_IRQ_ACK_N = 4'h4;
  localparam logic [ST_W-1:0] ST_MEM = 4'h8;
  // =========================================================
  // chip select decode: upper address byte of the responder window
  localparam int CS_LSB = 8;
  localparam logic [7:0] CS_PAGE = 8'h80;
  // =========================================================
  // timing
  localparam int REF_CLK_NS = 50;
  localparam int BUS_CLK_NS = 200;
  localparam int BUS_HALF = BUS_CLK_NS / (2 * REF_CLK_NS);
  localparam int RESP_WAIT = 4;
  localparam logic [7:0] IRQ_VECTOR = 8'h3c;
endpackage : bus_pkg

// file: design/shared_bus_if.sv
// shared bus wires and their resolution between the master and the responder
`timescale 1ns/1ps
interface shared_bus_if;
  import bus_pkg::*;
  // =========================================================
  // master drive
  logic bus_clk;
  logic reset_n;
  logic m_drive;
  logic m_as_n;
  logic m_ds_n;
  logic m_rw;
  logic m_bw;
  logic [ST_W-1:0] m_status;
  logic [EXT_W-1:0] m_ext;
  logic [DATA_W-1:0] m_ad_out;
  logic [1:0] m_ad_oe;
  logic bus_grant_n;
  // =========================================================
  // responder drive
  logic [DATA_W-1:0] r_ad_out;
  logic [DATA_W-1:0] r_ad_oe;
  logic r_wait_out;
  logic r_wait_oe;
  logic r_req_out;
  logic r_req_oe;
  logic grant_chain_out_n;
  logic irq_chain_out;
  // =========================================================
  // resolved lines; undriven lines float high through pull-ups
  logic addr_strobe_n;
  logic data_strobe_n;
  logic read_write;
  logic byte_word;
  logic [ST_W-1:0] status;
  logic [EXT_W-1:0] ext_addr;
  logic [DATA_W-1:0] muxed_addr_data;
  logic chip_sel_n;
  logic wait_n;
  logic bus_request_n;
  logic grant_chain_in_n;
  logic irq_chain_in;
  logic [DATA_W-1:0] m_mask;
  assign m_mask = {{8{m_ad_oe[1]}}, {8{m_ad_oe[0]}}};
  assign addr_strobe_n = m_drive ? m_as_n : 1'b1;
  assign data_strobe_n = m_drive ? m_ds_n : 1'b1;
  assign read_write = m_drive ? m_rw : 1'b1;
  assign byte_word = m_drive ? m_bw : 1'b1;
  assign status = m_drive ? m_status : '1;
  assign ext_addr = m_drive ? m_ext : '1;
  assign muxed_addr_data = (m_mask & m_ad_out) | (~m_mask & ((r_ad_oe & r_ad_out) | ~r_ad_oe));
  assign chip_sel_n = !(((status == ST_IO) || (status == ST_MEM))
                        && (muxed_addr_data[CS_LSB+:8] == CS_PAGE));
  assign wait_n = r_wait_oe ? r_wait_out : 1'b1;
  assign bus_request_n = r_req_oe ? r_req_out : 1'b1;
  assign grant_chain_in_n = bus_grant_n;
  assign irq_chain_in = 1'b1;
  modport master (
    output bus_clk, reset_n, m_drive, m_as_n, m_ds_n, m_rw, m_bw, m_status, m_ext,
    output m_ad_out, m_ad_oe, bus_grant_n,
    input muxed_addr_data, wait_n, bus_request_n
  );
  modport responder (
    output r_ad_out, r_ad_oe, r_wait_out, r_wait_oe, r_req_out, r_req_oe,
    output grant_chain_out_n, irq_chain_out,
    input reset_n, addr_strobe_n, data_strobe_n, read_write, byte_word, status,
    input muxed_addr_data, chip_sel_n, bus_request_n, grant_chain_in_n, irq_chain_in
  );
endinterface : shared_bus_if

// file: design/bus_master.sv
// bus master end: default-owner cpu that runs transactions and grants the bus
// Behaviour
// [R1] falling then rising address strobe starts each transaction
// [R2] direction low for write, high for read
// [R3] byte/word line: low word, high byte
// [R4] eight-bit bus moves data on low lines
// [R5] master stretches data phase while wait low
// [R6] reset line low resets cpu and users
// [R7] chip select latched at strobe rise
// [R8] master signals change only on bus clock; the code moves reset_n and reset-forced lines on any reference clock
// [R9] data strobe times every data movement
// [R10] one transaction at a time, master only
// [R11] status distinguishes memory, io, irq_ack_n, null
// [R12] bus request answered by acknowledge signal
// [R13] requester pulls request line, reads it back
// [R14] acknowledge only after bus released
// [R15] grant chain passes to lower priority
// [R16] cpu holds bus by default
// [R17] eight-bit peripheral uses low lines only
// [R18] irq_ack_n decoded from status lines
// [R19] extended address lines carry upper bits
// [R20] read releases lines before data strobe
// [R21] data strobe held high suppresses transfer
// [R22] responder drives lines only on selected read
`timescale 1ns/1ps
module bus_master #(
  parameter int HALF = bus_pkg::BUS_HALF,
  parameter bit BUS16 = 1'b1
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  shared_bus_if.master bus,
  input wire logic reset_req_i,
  input wire logic req_valid_i,
  input wire logic [bus_pkg::ST_W-1:0] req_status_i,
  input wire logic req_write_i,
  input wire logic req_byte_i,
  input wire logic req_suppress_i,
  input wire logic [bus_pkg::ADDR_W-1:0] req_addr_i,
  input wire logic [bus_pkg::EXT_W-1:0] req_ext_i,
  input wire logic [bus_pkg::DATA_W-1:0] req_wdata_i,
  output logic req_ready_o,
  output logic done_o,
  output logic [bus_pkg::DATA_W-1:0] rdata_o,
  output logic bus_released_o
);
  import bus_pkg::*;

  if (HALF < 1 || HALF > 255) begin : g_bad_half
    $error("bus_master: HALF must lie in 1..255");
  end

  // =========================================================
  // state
  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_LATCH, S_GAP, S_DATA1, S_DATA2, S_END, S_DROP, S_GRANT
  } state_e;

  typedef struct packed {
    state_e st;
    logic [7:0] div;
    logic bclk;
    logic [1:0] wait_s;
    logic [1:0] req_s;
    logic [1:0][DATA_W-1:0] ad_s;
    logic rst_n;
    logic drive;
    logic as_n;
    logic ds_n;
    logic rw;
    logic bw;
    logic [ST_W-1:0] status;
    logic [EXT_W-1:0] ext;
    logic [DATA_W-1:0] ad_out;
    logic [1:0] ad_oe;
    logic [DATA_W-1:0] wdata;
    logic grant_n;
    logic skip;
    logic ready;
    logic done;
    logic [DATA_W-1:0] rdata;
    logic rel;
  } m_s;

  localparam logic [7:0] DIV_TOP = 8'(HALF - 1);

  m_s q;
  m_s n;
  logic tick;
  logic is_null;
  logic is_read;

  // =========================================================
  // next state
  always_comb begin
    n = q;
    n.done = 1'b0;
    // pins from outside the clock domain pass two flops first
    n.wait_s = {q.wait_s[0], bus.wait_n};
    n.req_s = {q.req_s[0], bus.bus_request_n};
    n.ad_s = {q.ad_s[0], bus.muxed_addr_data};
    n.rst_n = !reset_req_i; // [R6]
    // bus clock made here by dividing the reference clock
    tick = (q.div == DIV_TOP) && !q.bclk; // [R8]
    if (q.div == DIV_TOP) begin
      n.div = 8'h00;
      n.bclk = !q.bclk;
    end else begin
      n.div = q.div + 8'h01;
    end
    is_null = (q.status == ST_NULL) || (q.status == ST_REFRESH) || q.skip; // [R11] [R21]
    is_read = q.rw;
    if (!q.rst_n) begin
      // a reset request pulls the whole bus back to its idle master
      n.st = S_IDLE; // [R6]
      n.drive = 1'b1; // [R16]
      n.as_n = 1'b1;
      n.ds_n = 1'b1;
      n.ad_oe = 2'b00;
      n.grant_n = 1'b1;
    end else if (tick) begin
      case (q.st)
        S_IDLE: begin
          if (req_valid_i && q.ready) begin
            // one transaction at a time, taken only while we own the bus
            n.status = req_status_i; // [R10] [R11]
            n.rw = !req_write_i || (req_status_i == ST_IRQ_ACK_N); // [R2]
            n.bw = BUS16 ? req_byte_i : 1'b0; // [R3]
            n.ext = req_ext_i; // [R19]
            n.ad_out = req_addr_i;
            n.ad_oe = 2'b11;
            n.wdata = req_wdata_i;
            n.skip = req_suppress_i;
            n.as_n = 1'b0; // [R1]
            n.st = S_ADDR;
          end else if (!q.req_s[1]) begin
            // float every line first, acknowledge one bus clock later
            n.drive = 1'b0; // [R14]
            n.ad_oe = 2'b00;
            n.st = S_DROP;
          end
        end
        S_ADDR: begin
          n.as_n = 1'b1; // [R1]
          n.st = S_LATCH;
        end
        S_LATCH: begin
          if (is_null) begin
            n.st = S_END; // [R21]
          end else if (is_read) begin
            // eight-bit bus leaves the upper address byte standing
            n.ad_oe = BUS16 ? 2'b00 : 2'b10; // [R20] [R4]
            n.st = S_GAP;
          end else begin
            n.ad_out = BUS16 ? q.wdata : {q.ad_out[15:8], q.wdata[7:0]}; // [R4] [R20]
            n.st = S_GAP;
          end
        end
        S_GAP: begin
          n.ds_n = 1'b0; // [R9]
          n.st = S_DATA1;
        end
        S_DATA1: begin
          // minimum two bus clocks so a slow responder's wait is seen
          n.st = S_DATA2;
        end
        S_DATA2: begin
          if (q.wait_s[1]) begin // [R5]
            if (is_read) begin
              n.rdata = BUS16 ? q.ad_s[1] : {8'h00, q.ad_s[1][7:0]}; // [R20] [R4]
            end
            n.ds_n = 1'b1; // [R9]
            n.st = S_END;
          end
        end
        S_END: begin
          n.ad_oe = 2'b00;
          n.done = 1'b1;
          n.st = S_IDLE;
        end
        S_DROP: begin
          n.grant_n = 1'b0; // [R14] [R12]
          n.st = S_GRANT;
        end
        S_GRANT: begin
          if (q.req_s[1]) begin
            // requester let go: take default ownership back
            n.grant_n = 1'b1; // [R16]
            n.drive = 1'b1;
            n.st = S_IDLE;
          end
        end
        default: begin
          n.st = S_IDLE;
        end
      endcase
    end
    // ready marks the cycle whose closing edge is an idle bus tick
    n.ready = (n.st == S_IDLE) && n.rst_n && n.drive && (n.div == DIV_TOP) && !n.bclk;
    n.rel = !n.grant_n; // [R14]
  end

  // =========================================================
  // registers
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '{st: S_IDLE, div: 8'h00, bclk: 1'b0, wait_s: 2'b11, req_s: 2'b11, ad_s: '0,
             rst_n: 1'b0, drive: 1'b1, as_n: 1'b1, ds_n: 1'b1, rw: 1'b1, bw: 1'b0,
             status: ST_NULL, ext: '0, ad_out: '0, ad_oe: 2'b00, wdata: '0, grant_n: 1'b1,
             skip: 1'b0, ready: 1'b0, done: 1'b0, rdata: '0, rel: 1'b0};
    end else begin
      q <= n;
    end
  end

  // =========================================================
  // outputs
  assign bus.bus_clk = q.bclk;
  assign bus.reset_n = q.rst_n;
  assign bus.m_drive = q.drive;
  assign bus.m_as_n = q.as_n;
  assign bus.m_ds_n = q.ds_n;
  assign bus.m_rw = q.rw;
  assign bus.m_bw = q.bw;
  assign bus.m_status = q.status;
  assign bus.m_ext = q.ext;
  assign bus.m_ad_out = q.ad_out;
  assign bus.m_ad_oe = q.ad_oe;
  assign bus.bus_grant_n = q.grant_n;
  assign req_ready_o = q.ready;
  assign done_o = q.done;
  assign rdata_o = q.rdata;
  assign bus_released_o = q.rel;
endmodule : bus_master

// file: design/bus_responder.sv
// responder end: strobe-timed register peripheral that can also request the bus
`timescale 1ns/1ps
module bus_responder #(
  parameter bit PERIPH16 = 1'b1,
  parameter int DEPTH = 16,
  parameter int WAIT_CYC = bus_pkg::RESP_WAIT
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  shared_bus_if.responder bus,
  input wire logic want_bus_i,
  output logic bus_owned_o,
  output logic [bus_pkg::DATA_W-1:0] user_word_o,
  output logic write_pulse_o,
  output logic in_reset_o
);
  import bus_pkg::*;

  localparam int IW = $clog2(DEPTH);

  if (DEPTH < 2 || DEPTH > 256 || (1 << IW) != DEPTH || WAIT_CYC < 0 || WAIT_CYC > 255) begin : g_bad
    $error("bus_responder: DEPTH must be a power of two 2..256, WAIT_CYC 0..255");
  end

  // =========================================================
  // state
  typedef struct packed {
    logic [1:0] as_s;
    logic [1:0] ds_s;
    logic [1:0] rw_s;
    logic [1:0] bw_s;
    logic [1:0] cs_s;
    logic [1:0] rst_s;
    logic [1:0] gin_s;
    logic [1:0] ien_s;
    logic [1:0] req_s;
    logic [1:0][ST_W-1:0] st_s;
    logic [1:0][DATA_W-1:0] ad_s;
    logic as_prev;
    logic ds_prev;
    logic sel;
    logic ack;
    logic rd;
    logic byt;
    logic [IW-1:0] idx;
    logic [7:0] wcnt;
    logic [DEPTH-1:0][DATA_W-1:0] regs;
    logic [DATA_W-1:0] ad_out;
    logic [DATA_W-1:0] ad_oe;
    logic wait_oe;
    logic req_oe;
    logic chain_n;
    logic irq_out;
    logic owned;
    logic wr;
    logic [DATA_W-1:0] word;
    logic in_rst;
  } r_s;

  localparam logic [7:0] WAIT_LOAD = 8'(WAIT_CYC);

  r_s q;
  r_s n;
  logic as_rise;
  logic ds_fall;
  logic ds_rise;
  logic bus_rst;
  logic [DATA_W-1:0] rword;
  logic [DATA_W-1:0] lanes;

  // =========================================================
  // next state
  always_comb begin
    n = q;
    n.wr = 1'b0;
    // timing comes only from the strobes, seen through two flops
    n.as_s = {q.as_s[0], bus.addr_strobe_n}; // [R8]
    n.ds_s = {q.ds_s[0], bus.data_strobe_n};
    n.rw_s = {q.rw_s[0], bus.read_write};
    n.bw_s = {q.bw_s[0], bus.byte_word};
    n.cs_s = {q.cs_s[0], bus.chip_sel_n};
    n.rst_s = {q.rst_s[0], bus.reset_n};
    n.gin_s = {q.gin_s[0], bus.grant_chain_in_n};
    n.ien_s = {q.ien_s[0], bus.irq_chain_in};
    n.st_s = {q.st_s[0], bus.status};
    n.ad_s = {q.ad_s[0], bus.muxed_addr_data};
    n.as_prev = q.as_s[1];
    n.ds_prev = q.ds_s[1];
    as_rise = !q.as_prev && q.as_s[1];
    ds_fall = q.ds_prev && !q.ds_s[1];
    ds_rise = !q.ds_prev && q.ds_s[1];
    // reset line low, or both strobes low together, is the peripheral reset
    bus_rst = !q.rst_s[1] || (!q.as_s[1] && !q.ds_s[1]); // [R6]
    n.in_rst = bus_rst;
    rword = q.ack ? {8'h00, IRQ_VECTOR} : q.regs[q.idx];
    lanes = (PERIPH16 && !q.byt) ? '1 : {{8{1'b0}}, {8{1'b1}}}; // [R17] [R4]
    // requester side: pull request, let grant pass when not wanted
    n.req_oe = want_bus_i; // [R13]
    n.req_s = {q.req_s[0], bus.bus_request_n};
    // owned once the grant reaches us and our own pull shows on the line
    n.owned = want_bus_i && !q.gin_s[1] && !q.req_s[1]; // [R15]
    n.chain_n = want_bus_i || q.gin_s[1]; // [R15]
    n.irq_out = q.ien_s[1];
    if (bus_rst) begin
      n.sel = 1'b0;
      n.ack = 1'b0;
      n.wcnt = 8'h00;
      n.wait_oe = 1'b0;
      n.ad_oe = '0;
      n.regs = '0;
    end else begin
      if (as_rise) begin
        // the select, direction, width and index of the transaction are caught at the strobe rise
        n.ack = (q.st_s[1] == ST_IRQ_ACK_N) && q.ien_s[1]; // [R18] [R12]
        n.sel = !q.cs_s[1] || n.ack; // [R7]
        n.rd = q.rw_s[1] || n.ack; // [R2]
        n.byt = PERIPH16 ? q.bw_s[1] : 1'b1; // [R3] [R17]
        n.idx = q.ad_s[1][IW:1];
      end
      if (q.sel && ds_fall && (WAIT_CYC > 0)) begin
        n.wcnt = WAIT_LOAD;
        n.wait_oe = 1'b1; // [R5]
      end else if (q.wcnt > 8'h01) begin
        n.wcnt = q.wcnt - 8'h01;
      end else begin
        n.wcnt = 8'h00;
        n.wait_oe = 1'b0;
      end
      // drive only on a selected read while data strobe is low
      if (q.sel && q.rd && !q.ds_s[1]) begin // [R22] [R9]
        n.ad_out = rword;
        n.ad_oe = lanes;
      end else begin
        n.ad_oe = '0; // [R22]
      end
      // a write is taken as data strobe rises; no strobe, no transfer
      if (q.sel && !q.rd && ds_rise) begin // [R9] [R21]
        n.regs[q.idx] = q.byt ? {q.regs[q.idx][15:8], q.ad_s[1][7:0]} : q.ad_s[1]; // [R17]
        n.wr = 1'b1;
        n.word = n.regs[q.idx];
      end
      if (ds_rise || as_rise && !n.sel) begin
        n.sel = as_rise ? n.sel : 1'b0; // [R10]
      end
    end
  end

  // =========================================================
  // registers
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      // strobe, select and grant synchronisers start at the idle levels, the reset one low, so no false edge follows reset
      q <= '{as_s: 2'b11, ds_s: 2'b11, rw_s: 2'b11, bw_s: 2'b11, cs_s: 2'b11, gin_s: 2'b11, ien_s: 2'b11,
             req_s: 2'b11, as_prev: 1'b1, ds_prev: 1'b1, chain_n: 1'b1, in_rst: 1'b1, default: '0};
    end else begin
      q <= n;
    end
  end

  // =========================================================
  // outputs
  assign bus.r_ad_out = q.ad_out;
  assign bus.r_ad_oe = q.ad_oe;
  // open drain: the wait and request lines are only ever pulled low
  assign bus.r_wait_out = 1'b0; // [R5]
  assign bus.r_wait_oe = q.wait_oe;
  assign bus.r_req_out = 1'b0;
  assign bus.r_req_oe = q.req_oe;
  assign bus.grant_chain_out_n = q.chain_n;
  assign bus.irq_chain_out = q.irq_out;
  assign bus_owned_o = q.owned;
  assign user_word_o = q.word;
  assign write_pulse_o = q.wr;
  assign in_reset_o = q.in_rst;
endmodule : bus_responder

// file: test/shared_bus_assertions.sv
// concurrent checks on the shared bus lines between the master and responder ends
`timescale 1ns/1ps
module shared_bus_assertions (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic bus_clk,
  input wire logic reset_n,
  input wire logic m_drive,
  input wire logic [1:0] m_ad_oe,
  input wire logic addr_strobe_n,
  input wire logic data_strobe_n,
  input wire logic read_write,
  input wire logic [bus_pkg::ST_W-1:0] status,
  input wire logic chip_sel_n,
  input wire logic wait_n,
  input wire logic bus_request_n,
  input wire logic bus_grant_n,
  input wire logic [bus_pkg::DATA_W-1:0] r_ad_oe,
  input wire logic r_wait_out,
  input wire logic r_wait_oe,
  input wire logic r_req_out,
  input wire logic r_req_oe
);
  import bus_pkg::*;
  // ==========================================================
  // address phase as seen just before the strobe rises
  logic cs_lat;
  logic [ST_W-1:0] st_lat;
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cs_lat <= 1'b1;
      st_lat <= ST_NULL;
    end else if (!addr_strobe_n) begin
      cs_lat <= chip_sel_n;
      st_lat <= status;
    end
  end
  default clocking @(posedge ref_clk_i);
  endclocking
  // a bus reset may drop both strobes, so nothing is judged meanwhile
  default disable iff (!rst_b_i || !reset_n);
  // ==========================================================
  // protocol checks
  as_rise_a: assert property (
    $rose(addr_strobe_n) |-> data_strobe_n) else $error("data strobe low at address strobe rise");
  bus_clk_a: assert property (
    $changed(bus_clk) |=> $stable(bus_clk) ##1 $changed(bus_clk)) else $error("bus clock half period wrong");
  strobe_sync_a: assert property (
    ($changed(addr_strobe_n) && m_drive && $past(m_drive)) |-> $changed(bus_clk))
    else $error("address strobe moved off a bus clock edge");
  read_release_a: assert property (
    ($fell(data_strobe_n) && read_write) |-> ($past(m_ad_oe) == 2'b00) && (m_ad_oe == 2'b00))
    else $error("master still drives lines on read");
  write_data_a: assert property (
    ($fell(data_strobe_n) && !read_write) |-> $past(m_ad_oe[0])) else $error("write data not driven before strobe");
  wait_hold_a: assert property (
    $rose(data_strobe_n) |-> $past(wait_n)) else $error("data strobe ended while wait low");
  null_quiet_a: assert property (
    !data_strobe_n |-> (st_lat != ST_NULL) && (st_lat != ST_REFRESH)) else $error("data strobe in null transaction");
  resp_drive_a: assert property (
    (r_ad_oe != '0) |-> addr_strobe_n && (!cs_lat || (st_lat == ST_IRQ_ACK_N)))
    else $error("responder drives lines unselected");
  open_drain_a: assert property (
    !(r_wait_oe && r_wait_out) && !(r_req_oe && r_req_out)) else $error("open drain line driven high");
  grant_owner_a: assert property (
    !bus_grant_n |-> !m_drive) else $error("grant while master drives bus");
  grant_order_a: assert property (
    $fell(bus_grant_n) |-> !bus_request_n && !$past(bus_request_n)) else $error("grant without request");
endmodule : shared_bus_assertions

// file: test/tb_top.sv
// self-checking bench: master and responder ends joined by the shared bus
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  import bus_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic reset_req = 1'b0;
  logic req_valid = 1'b0;
  logic [ST_W-1:0] req_status = ST_NULL;
  logic req_write = 1'b0;
  logic req_byte = 1'b0;
  logic req_suppress = 1'b0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [EXT_W-1:0] req_ext = '0;
  logic [DATA_W-1:0] req_wdata = '0;
  logic want_bus = 1'b0;
  logic req_ready;
  logic done;
  logic bus_released;
  logic bus_owned;
  logic write_pulse;
  logic in_reset;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] user_word;
  logic [DATA_W-1:0] got;
  logic [31:0] seed = 32'he27a;
  logic [DATA_W-1:0] shadow [logic [ADDR_W-1:0]];
  int fails = 0;
  int cmp_count = 0;
  int pulses = 0;
  int exp_pulses = 0;
  // ==========================================================
  // the two ends and the checker
  shared_bus_if bus_if();
  bus_master i_bus_master (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .bus(bus_if.master), .reset_req_i(reset_req),
    .req_valid_i(req_valid), .req_status_i(req_status), .req_write_i(req_write), .req_byte_i(req_byte),
    .req_suppress_i(req_suppress), .req_addr_i(req_addr), .req_ext_i(req_ext), .req_wdata_i(req_wdata),
    .req_ready_o(req_ready), .done_o(done), .rdata_o(rdata), .bus_released_o(bus_released));
  bus_responder i_bus_responder (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .bus(bus_if.responder),
    .want_bus_i(want_bus), .bus_owned_o(bus_owned), .user_word_o(user_word), .write_pulse_o(write_pulse),
    .in_reset_o(in_reset));
  shared_bus_assertions i_shared_bus_assertions (.ref_clk_i(ref_clk), .rst_b_i(rst_b),
    .bus_clk(bus_if.bus_clk), .reset_n(bus_if.reset_n), .m_drive(bus_if.m_drive), .m_ad_oe(bus_if.m_ad_oe),
    .addr_strobe_n(bus_if.addr_strobe_n), .data_strobe_n(bus_if.data_strobe_n), .read_write(bus_if.read_write),
    .status(bus_if.status), .chip_sel_n(bus_if.chip_sel_n), .wait_n(bus_if.wait_n),
    .bus_request_n(bus_if.bus_request_n), .bus_grant_n(bus_if.bus_grant_n), .r_ad_oe(bus_if.r_ad_oe),
    .r_wait_out(bus_if.r_wait_out), .r_wait_oe(bus_if.r_wait_oe), .r_req_out(bus_if.r_req_out),
    .r_req_oe(bus_if.r_req_oe));
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (write_pulse === 1'b1) pulses++;
  end
  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // even addresses only, so any register index slice stays distinct
  function automatic logic [ADDR_W-1:0] page(input logic [2:0] k);
    return {CS_PAGE, 4'h0, k, 1'b0};
  endfunction : page
  function automatic logic sel(input logic [ST_W-1:0] st, input logic [ADDR_W-1:0] a);
    return ((st == ST_IO) || (st == ST_MEM)) && (a[15:8] == CS_PAGE);
  endfunction : sel
  task automatic xfer(input logic [ST_W-1:0] st, input logic wr, input logic by, input logic sup,
                      input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    logic hit;
    hit = wr && !sup && sel(st, a);
    req_status <= st;
    req_write <= wr;
    req_byte <= by;
    req_suppress <= sup;
    req_addr <= a;
    req_ext <= seed[EXT_W-1:0];
    req_wdata <= d;
    req_valid <= 1'b1;
    @(posedge ref_clk);
    for (n = 0; n < 400 && req_ready !== 1'b1; n++) @(posedge ref_clk);
    req_valid <= 1'b0;
    for (n = 0; n < 400 && done !== 1'b1; n++) @(posedge ref_clk);
    got = rdata;
    `CHK(done, 1'b1)
    if (hit) exp_pulses++;
    if (hit && !by) shadow[a] = d;
    if (hit && by) shadow.delete(a);
    @(posedge ref_clk);
  endtask : xfer
  task automatic end_of_test();
    if (fails == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (40000) @(posedge ref_clk);
    fails++;
    end_of_test();
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) xfer(ST_IO, 1'b1, 1'b0, 1'b0, page(i[2:0]), 16'hff00 >> i);
    for (int i = 0; i < 48; i++) begin
      seed = lfsr(seed);
      xfer(seed[3] ? ST_MEM : ST_IO, seed[4], 1'b0, 1'b0, page(seed[2:0]), seed[31:16]);
      if (!seed[4]) `CHK(got, shadow[page(seed[2:0])])
    end
    // unselected read sees the pull-ups only
    xfer(ST_IO, 1'b0, 1'b0, 1'b0, 16'h1234, '0);
    `CHK(got, 16'hffff)
    xfer(ST_IRQ_ACK_N, 1'b0, 1'b0, 1'b0, '0, '0);
    `CHK(got[7:0], IRQ_VECTOR)
    xfer(ST_NULL, 1'b1, 1'b0, 1'b0, page(3'h1), 16'hdead);
    xfer(ST_REFRESH, 1'b1, 1'b0, 1'b0, page(3'h2), 16'hbeef);
    xfer(ST_MEM, 1'b1, 1'b0, 1'b1, page(3'h1), 16'h0bad);
    for (int i = 1; i < 3; i++) begin
      xfer(ST_MEM, 1'b0, 1'b0, 1'b0, page(i[2:0]), '0);
      `CHK(got, shadow[page(i[2:0])])
    end
    xfer(ST_IO, 1'b1, 1'b1, 1'b0, page(3'h5), 16'h77aa);
    xfer(ST_IO, 1'b0, 1'b1, 1'b0, page(3'h5), '0);
    `CHK(got[7:0], 8'haa)
    want_bus <= 1'b1;
    for (int n = 0; n < 200 && bus_owned !== 1'b1; n++) @(posedge ref_clk);
    `CHK(bus_owned, 1'b1)
    `CHK(bus_released, 1'b1)
    want_bus <= 1'b0;
    for (int n = 0; n < 200 && bus_released !== 1'b0; n++) @(posedge ref_clk);
    `CHK(bus_owned, 1'b0)
    `CHK(bus_released, 1'b0)
    reset_req <= 1'b1;
    for (int n = 0; n < 200 && in_reset !== 1'b1; n++) @(posedge ref_clk);
    `CHK(in_reset, 1'b1)
    reset_req <= 1'b0;
    for (int n = 0; n < 200 && in_reset !== 1'b0; n++) @(posedge ref_clk);
    // bus reset clears the responder's registers
    xfer(ST_MEM, 1'b0, 1'b0, 1'b0, page(3'h1), '0);
    `CHK(got, 16'h0000)
    xfer(ST_IO, 1'b1, 1'b0, 1'b0, page(3'h6), 16'h5a5a);
    xfer(ST_IO, 1'b0, 1'b0, 1'b0, page(3'h6), '0);
    `CHK(got, 16'h5a5a)
    `CHK(user_word, 16'h5a5a)
    `CHK(pulses, exp_pulses)
    end_of_test();
  end
endmodule : tb_top
